//--- hdl/oet_top.sv
// off-loadable event timer: main counter, eight comparators, slow-clock off-load, apb slave
`include "oet_cfg.svh"
module oet_top #(
  parameter int NUM_TIMERS = `OET_NUM_TIMERS,
  parameter int CNT_W = `OET_CNT_W,
  parameter int SLOW_W = `OET_SLOW_W,
  parameter int FRAC_W = `OET_FRAC_W,
  parameter int INC_W = `OET_INC_W
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire oet_pkg::oet_apb_req_t apb_req_i,
  output oet_pkg::oet_apb_rsp_t apb_rsp_o,
  input wire logic rtc_clk_i,
  input wire logic offload_req_i,
  input wire logic [INC_W-1:0] calib_inc_i,
  output logic slow_active_o,
  output logic [NUM_TIMERS-1:0] timer_irq_o
);
  localparam int TICK_CYC = 1;
  localparam int TICK_MAX_CYC = `OET_TICK_MAX_CYC;

  // bus decode
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  wire [`OET_ADDR_W-1:0] addr = {apb_req_i.paddr[`OET_ADDR_W-1:2], 2'h0};
  wire [2:0] t_idx = apb_req_i.paddr[6:4];
  wire [1:0] t_reg = apb_req_i.paddr[3:2];
  wire gen_hit = (addr == `OET_GEN_CFG);
  wire stat_hit = (addr == `OET_STATUS);
  wire lo_hit = (addr == `OET_CNT_LO);
  wire hi_hit = (addr == `OET_CNT_HI);
  wire tmr_hit = (apb_req_i.paddr[11:7] == `OET_TMR_PAGE) && (t_reg != 2'h3);
  wire addr_ok = gen_hit | stat_hit | lo_hit | hi_hit | tmr_hit;
  wire apb_acc = apb_req_i.psel & apb_req_i.penable;
  wire apb_first = apb_acc & ~pready_reg;
  wire apb_done = apb_acc & pready_reg;
  wire wr_en = apb_done & apb_req_i.pwrite & addr_ok;

  // control and state registers
  logic cnt_en_reg;
  logic leg_route_reg;
  logic per0_reg;
  logic [NUM_TIMERS-1:0] tmr_ie_reg;
  logic [NUM_TIMERS-1:0] stat_reg;
  logic [NUM_TIMERS-1:0] stat_next;
  logic [CNT_W-1:0] main_cnt_reg;
  logic [CNT_W-1:0] main_cnt_next;
  logic [SLOW_W-1:0] slow_cnt_reg;
  logic [SLOW_W-1:0] slow_cnt_next;
  logic slow_active_reg;
  oet_pkg::oet_mode_t st_reg;
  oet_pkg::oet_mode_t st_next;
  logic [CNT_W-1:0] cmp_val [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] match;

  // slow clock edge detection
  logic rtc_sync;
  logic rtc_d_reg;
  oet_sync #(
    .W(1)
  ) u_rtc_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .async_i(rtc_clk_i),
    .sync_o(rtc_sync)
  );
  wire slow_edge = rtc_sync & ~rtc_d_reg;

  // counter view and mode decisions
  wire in_fast = (st_reg == oet_pkg::ST_FAST);
  wire in_park = (st_reg == oet_pkg::ST_PARK);
  wire in_slow = (st_reg == oet_pkg::ST_SLOW);
  wire cmp_active = cnt_en_reg & (|tmr_ie_reg);
  wire offload_ok = offload_req_i & ~cmp_active;
  wire [SLOW_W-1:0] step = {{(SLOW_W-INC_W){1'b0}}, calib_inc_i};
  wire [SLOW_W-1:0] slow_sum = slow_cnt_reg + (cnt_en_reg ? step : '0);
  wire [CNT_W-1:0] slow_upper = slow_cnt_reg[SLOW_W-1:FRAC_W];
  wire [CNT_W-1:0] cnt_view = in_slow ? slow_upper : main_cnt_reg;
  wire cnt_wr_ok = in_fast & ~cnt_en_reg;
  wire cnt_wr_lo = wr_en & lo_hit & cnt_wr_ok;
  wire cnt_wr_hi = wr_en & hi_hit & cnt_wr_ok;

  // mode sequencer
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      oet_pkg::ST_FAST: begin
        if (offload_ok && slow_edge) begin
          st_next = oet_pkg::ST_PARK;
        end
      end
      oet_pkg::ST_PARK: begin
        if (slow_edge) begin
          st_next = offload_req_i ? oet_pkg::ST_SLOW : oet_pkg::ST_FAST;
        end
      end
      oet_pkg::ST_SLOW: begin
        if (slow_edge && !offload_req_i) begin
          st_next = oet_pkg::ST_FAST;
        end
      end
      default: begin
        st_next = oet_pkg::ST_FAST;
      end
    endcase
  end

  // counter next values
  always_comb begin
    main_cnt_next = main_cnt_reg;
    slow_cnt_next = slow_cnt_reg;
    if (in_fast) begin
      if (offload_ok && slow_edge) begin
        slow_cnt_next = {main_cnt_reg, slow_cnt_reg[FRAC_W-1:0]};
      end else if (cnt_wr_lo) begin
        main_cnt_next[31:0] = apb_req_i.pwdata;
      end else if (cnt_wr_hi) begin
        main_cnt_next[CNT_W-1:32] = apb_req_i.pwdata[CNT_W-33:0];
      end else if (cnt_en_reg) begin
        main_cnt_next = main_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else if (slow_edge) begin
      if (in_park) begin
        slow_cnt_next = slow_sum;
        if (!offload_req_i) begin
          main_cnt_next = slow_sum[SLOW_W-1:FRAC_W];
        end
      end else if (offload_req_i) begin
        slow_cnt_next = slow_sum;
      end else begin
        main_cnt_next = slow_upper;
      end
    end
  end

  // interrupt status, set wins over software clear
  wire [NUM_TIMERS-1:0] stat_clr = (wr_en & stat_hit) ? apb_req_i.pwdata[NUM_TIMERS-1:0] : '0;
  assign stat_next = (stat_reg & ~stat_clr) | (match & tmr_ie_reg);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= oet_pkg::ST_FAST;
      main_cnt_reg <= '0;
      slow_cnt_reg <= '0;
      slow_active_reg <= 1'b0;
      rtc_d_reg <= 1'b0;
      stat_reg <= '0;
    end else begin
      st_reg <= st_next;
      main_cnt_reg <= main_cnt_next;
      slow_cnt_reg <= slow_cnt_next;
      slow_active_reg <= (st_next != oet_pkg::ST_FAST);
      rtc_d_reg <= rtc_sync;
      stat_reg <= stat_next;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_en_reg <= 1'b0;
      leg_route_reg <= 1'b0;
      per0_reg <= 1'b0;
      tmr_ie_reg <= '0;
    end else if (wr_en && gen_hit) begin
      cnt_en_reg <= apb_req_i.pwdata[`OET_GEN_EN_BIT];
      leg_route_reg <= apb_req_i.pwdata[`OET_GEN_LEG_BIT];
    end else if (wr_en && tmr_hit && t_reg == `OET_TMR_CFG) begin
      tmr_ie_reg[t_idx] <= apb_req_i.pwdata[`OET_TCFG_IE_BIT];
      if (t_idx == 3'h0) begin
        per0_reg <= apb_req_i.pwdata[`OET_TCFG_PER_BIT];
      end
    end
  end

  // comparators
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
      wire sel = wr_en & tmr_hit & (t_idx == 3'(gi));
      oet_cmp #(
        .PERIODIC_EN(gi == 0),
        .CNT_W(CNT_W)
      ) u_cmp (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .cnt_i(cnt_view),
        .periodic_i(per0_reg),
        .wr_lo_i(sel & (t_reg == `OET_TMR_CMP_LO)),
        .wr_hi_i(sel & (t_reg == `OET_TMR_CMP_HI)),
        .wdata_i(apb_req_i.pwdata),
        .cmp_o(cmp_val[gi]),
        .match_o(match[gi])
      );
    end
  endgenerate

  // read data selection
  wire [CNT_W-1:0] cmp_sel = cmp_val[t_idx];
  wire per_rd = (t_idx == 3'h0) & per0_reg;
  wire [31:0] tcfg_rd = {30'h0, per_rd, tmr_ie_reg[t_idx]};
  wire [31:0] tmr_rd = (t_reg == `OET_TMR_CFG) ? tcfg_rd :
                       (t_reg == `OET_TMR_CMP_LO) ? cmp_sel[31:0] : cmp_sel[CNT_W-1:32];
  wire [31:0] stat_rd = {23'h0, slow_active_reg, stat_reg};
  wire [31:0] rd_word = gen_hit ? {30'h0, leg_route_reg, cnt_en_reg} :
                        stat_hit ? stat_rd :
                        lo_hit ? cnt_view[31:0] :
                        hi_hit ? cnt_view[CNT_W-1:32] :
                        tmr_hit ? tmr_rd : 32'h0000_0000;

  // apb answer: one wait state, read data captured in the first access cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= apb_first;
      pslverr_reg <= apb_first & ~addr_ok;
      if (apb_first && !apb_req_i.pwrite) begin
        prdata_reg <= rd_word;
      end
    end
  end

  assign apb_rsp_o.prdata = prdata_reg;
  assign apb_rsp_o.pready = pready_reg;
  assign apb_rsp_o.pslverr = pslverr_reg;
  assign slow_active_o = slow_active_reg;
  assign timer_irq_o = stat_reg;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_TICK_LIMIT: assert property (TICK_CYC <= TICK_MAX_CYC)
    else $error("counter tick longer than allowed");
  AST_FAST_INC: assert property (
    (in_fast && cnt_en_reg && !slow_edge) |=> (main_cnt_reg == $past(main_cnt_reg) + 64'h1))
    else $error("fast counter did not add one");
  AST_MODE_ON_EDGE: assert property ((st_next != st_reg) |-> slow_edge)
    else $error("mode changed without a slow edge");
  AST_REFUSE_ACTIVE: assert property ((in_fast && cmp_active) |=> in_fast)
    else $error("off-load entered with an active comparator");
  AST_PARK_LOAD: assert property (
    (in_fast && offload_ok && slow_edge) |=> (in_park && slow_upper == $past(main_cnt_reg)))
    else $error("parked count not placed in the upper bits");
  AST_FROZEN: assert property ((in_park && !slow_edge) |=> $stable(main_cnt_reg))
    else $error("frozen counter moved");
  AST_SLOW_ADD: assert property (
    (in_slow && slow_edge && offload_req_i && cnt_en_reg) |=>
    (slow_cnt_reg == $past(slow_cnt_reg) + $past(step)))
    else $error("slow counter did not add the step");
  AST_RETURN: assert property (
    (in_slow && slow_edge && !offload_req_i) |=>
    (in_fast && !slow_active_o && main_cnt_reg == $past(slow_upper)))
    else $error("return did not reload the fast count");
  AST_FRAC_KEEP: assert property (
    (in_slow && slow_edge && !offload_req_i) |=> ##[1:3] (slow_cnt_reg[FRAC_W-1:0] == $past(slow_cnt_reg[FRAC_W-1:0], 2)))
    else $error("fraction bits lost on return");
  AST_BOTH_ONE_EDGE: assert property (
    (in_park && slow_edge && !offload_req_i) |=> (in_fast && main_cnt_reg == $past(slow_sum[SLOW_W-1:FRAC_W])))
    else $error("entry and return not done on one edge");
  AST_MATCH_FLAG: assert property ((match[0] && tmr_ie_reg[0]) |=> timer_irq_o[0])
    else $error("match did not raise the timer flag");
  AST_SLOW_VIEW: assert property (in_slow |-> ##1 (!in_slow || cnt_view == slow_upper))
    else $error("slow mode view not from the slow counter");

  COV_ENTER_SLOW: cover property (in_park ##1 in_slow);
  COV_RETURN: cover property (in_slow ##1 in_fast);
  COV_SAME_EDGE: cover property (in_park ##1 in_fast);
  COV_MATCH: cover property (|(match & tmr_ie_reg));
endmodule

//--- common/oet_cfg.svh
// register map, field positions and timing constants of the event timer
`ifndef OET_CFG_SVH
`define OET_CFG_SVH
`define OET_ADDR_W 12
`define OET_GEN_CFG 12'h000
`define OET_STATUS 12'h004
`define OET_CNT_LO 12'h008
`define OET_CNT_HI 12'h00C
`define OET_TMR_PAGE 5'h01
`define OET_TMR_CFG 2'h0
`define OET_TMR_CMP_LO 2'h1
`define OET_TMR_CMP_HI 2'h2
`define OET_GEN_EN_BIT 0
`define OET_GEN_LEG_BIT 1
`define OET_STAT_SLOW_BIT 8
`define OET_TCFG_IE_BIT 0
`define OET_TCFG_PER_BIT 1
`define OET_NUM_TIMERS 8
`define OET_CNT_W 64
`define OET_SLOW_W 82
`define OET_FRAC_W 18
`define OET_INC_W 28
`define OET_CLK_PERIOD_PS 5000
`define OET_TICK_MAX_NS 100
`define OET_TICK_MAX_CYC ((`OET_TICK_MAX_NS * 1000) / `OET_CLK_PERIOD_PS)
`define OET_SLOW_HZ 32768
`endif

//--- common/oet_pkg.sv
// types shared by the event timer modules
`include "oet_cfg.svh"
package oet_pkg;
  typedef enum logic [2:0] {
    ST_FAST = 3'b001,
    ST_PARK = 3'b010,
    ST_SLOW = 3'b100
  } oet_mode_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`OET_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } oet_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } oet_apb_rsp_t;
endpackage

//--- hdl/oet_sync.sv
// two-flop synchroniser
module oet_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end
  assign sync_o = sync_reg;
endmodule

//--- hdl/oet_cmp.sv
// one timer comparator with optional periodic reload
module oet_cmp #(
  parameter bit PERIODIC_EN = 1'b0,
  parameter int CNT_W = 64
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [CNT_W-1:0] cnt_i,
  input wire logic periodic_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [31:0] wdata_i,
  output logic [CNT_W-1:0] cmp_o,
  output logic match_o
);
  logic [CNT_W-1:0] cmp_reg;
  logic [CNT_W-1:0] cmp_next;
  logic [CNT_W-1:0] period_reg;
  logic [CNT_W-1:0] period_next;
  logic eq_d_reg;
  wire eq = (cnt_i == cmp_reg);
  wire match = eq & ~eq_d_reg;
  wire per_on = PERIODIC_EN & periodic_i;
  always_comb begin
    cmp_next = cmp_reg;
    period_next = period_reg;
    if (wr_lo_i) begin
      cmp_next[31:0] = wdata_i;
      period_next[31:0] = wdata_i;
    end else if (wr_hi_i) begin
      cmp_next[CNT_W-1:32] = wdata_i[CNT_W-33:0];
      period_next[CNT_W-1:32] = wdata_i[CNT_W-33:0];
    end else if (match && per_on) begin
      cmp_next = cmp_reg + period_reg;
    end
  end
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_reg <= '1;
      period_reg <= '0;
      eq_d_reg <= 1'b0;
    end else begin
      cmp_reg <= cmp_next;
      period_reg <= period_next;
      eq_d_reg <= eq;
    end
  end
  assign cmp_o = cmp_reg;
  assign match_o = match;
  AST_PERIOD_ADD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (match && per_on && !wr_lo_i && !wr_hi_i) |=> (cmp_reg == $past(cmp_reg) + $past(period_reg)))
    else $error("periodic comparator did not advance by the period");
  AST_ONESHOT_KEEP: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (!per_on && !wr_lo_i && !wr_hi_i) |=> $stable(cmp_reg))
    else $error("non-periodic comparator changed without a write");
endmodule

//--- tb/oet_pwr_model.sv
// power manager and calibrator model: slow clock, off-load request, calibration step
module oet_pwr_model (
  input wire logic sys_clk_i,
  input wire logic idle_i,
  input wire logic [27:0] step_i,
  output logic rtc_clk_o,
  output logic offload_req_o,
  output logic [27:0] calib_inc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // free-running 32.768 kHz clock
  initial begin
    rtc_clk_o = 1'b0;
    offload_req_o = 1'b0;
    calib_inc_o = 28'h0;
    forever #15258.789 rtc_clk_o = ~rtc_clk_o;
  end
  // request held as a level in the fast domain for the whole idle
  always @(posedge sys_clk_i) begin
    offload_req_o <= idle_i;
    calib_inc_o <= step_i;
  end
endmodule

//--- tb/offloadable_event_timer_tb.sv
// testbench of the event timer: apb tasks, timer and off-load sequences
module offloadable_event_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, resetn_i, idle, slow_active, rtc_clk, offload_req, e;
  logic [27:0] step, calib_inc;
  logic [7:0] irq;
  logic [11:0] a;
  logic [31:0] v, f, w;
  oet_pkg::oet_apb_req_t req;
  oet_pkg::oet_apb_rsp_t rsp;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  oet_top oet_top_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .rtc_clk_i(rtc_clk), .offload_req_i(offload_req), .calib_inc_i(calib_inc),
    .slow_active_o(slow_active), .timer_irq_o(irq));
  oet_pwr_model oet_pwr_model_i (.sys_clk_i(sys_clk_i), .idle_i(idle), .step_i(step),
    .rtc_clk_o(rtc_clk), .offload_req_o(offload_req), .calib_inc_o(calib_inc));

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got);
    tests_run++;
    if (got !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t condition not met", $time);
    end
  endtask

  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    req <= '{1'b1, 1'b0, wr, ad, d};
    @(posedge sys_clk_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t no bus answer", $time);
    end
    v = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wait_slow(input logic lvl);
    int n;
    n = 0;
    while (slow_active !== lvl && n < 7000) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk_flag(slow_active === lvl);
  endtask

  // read the low counter word until it moves
  task automatic poll(input logic [31:0] old);
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h008, 32'h0);
      n++;
    end while (v === old && n < 2500);
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    resetn_i = 1'b0;
    req = '0;
    idle = 1'b0;
    step = 28'h0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk_word(v, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(v, 32'h0);
    apb(1'b0, 12'h08C, 32'h0);
    chk_flag(e);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b0, 12'h000, 32'h0);
    chk_word(v, 32'h2);
    apb(1'b1, 12'h080, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk_word(v, 32'h0);
    $display("test reset done");
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    w = v;
    apb(1'b0, 12'h008, 32'h0);
    chk_word(v, w + 32'h4);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(v, w + 32'hC);
    $display("test counting done");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00C, 32'h0);
    for (int n = 0; n < 8; n++) begin
      a = 12'(12'h080 + n * 16);
      apb(1'b1, a + 12'h4, 32'(32'h28 + 4 * n));
      apb(1'b1, a + 12'h8, 32'h0);
      apb(1'b1, a, (n == 3) ? 32'h3 : 32'h1);
    end
    apb(1'b0, 12'h0B0, 32'h0);
    chk_word(v, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    repeat (100) @(posedge sys_clk_i);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(v, 32'hFF);
    chk_word({24'h0, irq}, 32'hFF);
    apb(1'b1, 12'h004, 32'hFF);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(v, 32'h0);
    apb(1'b0, 12'h094, 32'h0);
    chk_word(v, 32'h2C);
    $display("test timers done");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    for (int n = 0; n < 8; n++) apb(1'b1, 12'(12'h080 + n * 16), 32'h0);
    apb(1'b1, 12'h084, 32'h3C);
    apb(1'b1, 12'h088, 32'h0);
    apb(1'b1, 12'h080, 32'h3);
    apb(1'b1, 12'h000, 32'h1);
    repeat (80) @(posedge sys_clk_i);
    apb(1'b0, 12'h084, 32'h0);
    chk_word(v, 32'h78);
    repeat (60) @(posedge sys_clk_i);
    apb(1'b0, 12'h084, 32'h0);
    chk_word(v, 32'hB4);
    $display("test periodic done");
    idle <= 1'b1;
    repeat (13000) @(posedge sys_clk_i);
    chk_flag(slow_active === 1'b0);
    idle <= 1'b0;
    apb(1'b1, 12'h080, 32'h0);
    $display("test refusal done");
    step <= 28'h0170000;
    idle <= 1'b1;
    wait_slow(1'b1);
    apb(1'b0, 12'h008, 32'h0);
    f = v;
    apb(1'b0, 12'h008, 32'h0);
    chk_word(v, f);
    poll(f);
    chk_word(v, f + 32'h5);
    poll(v);
    chk_word(v, f + 32'hB);
    idle <= 1'b0;
    wait_slow(1'b0);
    apb(1'b0, 12'h008, 32'h0);
    w = v;
    chk_flag(w >= f + 32'hB && w <= f + 32'h1B);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(v, w + 32'h4);
    $display("test offload done");
    idle <= 1'b1;
    wait_slow(1'b1);
    apb(1'b0, 12'h008, 32'h0);
    f = v;
    idle <= 1'b0;
    wait_slow(1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk_flag(v >= f + 32'h6 && v <= f + 32'h16);
    $display("test combined return done");
    test_done();
  end
endmodule
